// file: logic/sarc_pkg.sv
// constants, map and types of the session auth / read counter block
// assumes a single clock domain and an AHB-Lite word bus
package sarc_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] A_CMD   = 8'h00;
	localparam logic [7:0] A_STAT  = 8'h04;
	localparam logic [7:0] A_TID   = 8'h08;
	localparam logic [7:0] A_CCTR  = 8'h0c;
	localparam logic [7:0] A_ECTR  = 8'h10;
	localparam logic [7:0] A_RCTR  = 8'h14;
	localparam logic [7:0] A_ASCLO = 8'h18;
	localparam logic [7:0] A_ASCHI = 8'h1c;
	localparam logic [7:0] A_LIMIT = 8'h20;
	localparam logic [7:0] A_KCFG  = 8'h24;
	localparam logic [3:0] A_RCHAL = 4'h4; // 0x40..0x4c
	localparam logic [3:0] A_TCHAL = 4'h5; // 0x50..0x5c
	localparam logic [2:0] A_SVEC  = 3'h3; // 0x60..0x7c
	// ==========================================
	// command word fields
	localparam int F_FILE  = 4;
	localparam int F_ORIG  = 9;
	localparam int F_CHAIN = 10;
	localparam int F_SDMEN = 11;
	localparam int F_PAD   = 12;
	localparam int F_LEN   = 16;
	localparam int F_LIMEN = 24;
	// ==========================================
	// derivation constants and limits
	localparam logic [15:0] KDF_CTR   = 16'h0001;
	localparam logic [15:0] KDF_LEN   = 16'h0080;
	localparam logic [15:0] KDF_LABEL = 16'h9669;
	localparam logic [23:0] LIM_MAX   = 24'h0fffff;
	localparam logic [23:0] RCTR_RST  = 24'h000000;
	localparam logic [31:0] KCFG_VAL  = 32'h0000_1010; // plaintexts 16, integ idx 0, cipher idx 1
	// ==========================================
	typedef enum logic [3:0] {
		OP_OTHER  = 4'h0, OP_FIRST = 4'h1, OP_RESUME = 4'h2, OP_P2OK = 4'h3,
		OP_P2FAIL = 4'h4, OP_NRD   = 4'h5, OP_BRD    = 4'h6, OP_FSET = 4'h7,
		OP_FQRY   = 4'h8, OP_CRYPT = 4'h9
	} sarc_op_t;
	typedef enum logic [1:0] {
		AU_NONE = 2'b00, AU_WFIRST = 2'b01, AU_WRES = 2'b10, AU_LRP = 2'b11
	} sarc_auth_t;
	localparam logic [1:0] RT_NONE = 2'h0;
	localparam logic [1:0] RT_NAT  = 2'h1;
	localparam logic [1:0] RT_BIN  = 2'h2;
endpackage

// file: logic/sarc_top.sv
// session auth state, channel counters and dynamic read counter, AHB-Lite slave
// assumes one master, single word transfers, commands decoded by firmware
//
// Operation
// - refuse resume auth unless leak resilient session active or origin key targeted
// - resume auth keeps transaction id and command counter, no capability bytes
// - cipher block counter cleared at start of either authentication
// - resume success stays authenticated; origin key target ends not authenticated
// - any authentication failure leaves not authenticated state
// - integrity key in both variants, cipher key only in first auth
// - derivation input uses counter 0001h, length 0080h, label 9669h
// - session vector byte order from both challenges with XOR middle
// - root key MAC; first update key integrity, second cipher, 16 plaintexts
// - read counter is 24 bits, cleared when dynamic messaging enabled
// - counter binary LSB first, ASCII form MSB first
// - first successful unauthenticated read increments counter before answer
// - same type same file reads reuse value until another command
// - switching read type counts as a new first read
// - authenticated reads leave the counter unchanged
// - first read at limit, or FFFFFh without limit, answers error
// - chained command sequence counts as one command
// - limit held as three bytes, set by settings write, read back
// - at limit both read types blocked unauthenticated, authenticated allowed
// - disabled limit behaves as limit FFFFFh
// - cipher block counter advances per 16 byte block including padding
`timescale 1ns/100ps
module sarc_top
	import sarc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	// ==========================================
	// state
	typedef struct packed {
		sarc_auth_t   auth;
		logic         origin;
		logic         err;
		logic [31:0]  tid;
		logic [31:0]  tidSeed;
		logic [15:0]  command_counter;
		logic [31:0]  cipher_block_counter;
		logic [23:0]  rcnt;
		logic [23:0]  limit;
		logic         limEn;
		logic [23:0]  limStage;
		logic         limStageEn;
		logic         sdmOn;
		logic [4:0]   sdmFile;
		logic [1:0]   lastType;
		logic [4:0]   lastFile;
		logic [127:0] chalA;
		logic [127:0] chalB;
		logic [7:0]   dpAddr;
		logic         wrPend;
		logic         rdPend;
		logic         ready;
		logic         resp;
		logic [31:0]  rdata;
	} sarc_state_t;

	sarc_state_t s_r;
	sarc_state_t s_nxt;

	// ==========================================
	// helpers
	// blocks of 16 bytes; padding adds a block only when the length is a whole number of blocks
	function automatic logic [4:0] sarc_blocks(input logic [7:0] len, input logic pad);
		logic [4:0] b;
		b = {1'b0, len[7:4]};
		if (pad || (len[3:0] != 4'h0))
			b = b + 5'd1;
		return b;
	endfunction

	function automatic logic [7:0] sarc_asc(input logic [3:0] nib);
		return (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
	endfunction

	logic [255:0] svVec;
	logic [23:0]  effLim;
	// vector byte 0 sits in the top bits
	assign svVec = {KDF_CTR, KDF_LEN, s_r.chalA[127:112],
		s_r.chalA[111:64] ^ s_r.chalB[127:80], s_r.chalB[79:0],
		s_r.chalA[63:0], KDF_LABEL};
	// disabled limit is the top value
	assign effLim = s_r.limEn ? s_r.limit : LIM_MAX;

	// command fields, valid while a command write is in its data phase
	logic       cmdFire;
	sarc_op_t   cOp;
	logic [4:0] cFile;
	logic       cChain;
	logic       cRead;
	logic [1:0] cType;
	logic       cFirst;
	assign cmdFire = s_r.wrPend && (s_r.dpAddr == A_CMD);
	assign cOp     = sarc_op_t'(hwdata[3:0]);
	assign cFile   = hwdata[F_FILE +: 5];
	assign cChain  = hwdata[F_CHAIN];
	assign cRead   = (cOp == OP_NRD) || (cOp == OP_BRD);
	assign cType   = (cOp == OP_NRD) ? RT_NAT : RT_BIN;
	// type change or other file makes it a first read
	assign cFirst  = !((s_r.lastType == cType) && (s_r.lastFile == cFile));

	logic waitAuth;
	assign waitAuth = (s_r.auth == AU_WFIRST) || (s_r.auth == AU_WRES);

	// ==========================================
	// next state
	always_comb begin
		sarc_auth_t authNow;
		logic [31:0] rd;
		authNow = s_r.auth;
		rd = 32'h0000_0000;
		s_nxt = s_r;
		s_nxt.wrPend = 1'b0;

		// read mux; unmapped offsets read zero
		case (s_r.dpAddr)
			A_CMD:   rd = 32'h0000_0000;
			A_STAT:  rd = {20'h0, s_r.lastFile, s_r.lastType,
				s_r.auth == AU_WFIRST, waitAuth, s_r.err, s_r.auth};
			A_TID:   rd = s_r.tid;
			A_CCTR:  rd = {16'h0, s_r.command_counter};
			A_ECTR:  rd = s_r.cipher_block_counter;
			A_RCTR:  rd = {8'h00, s_r.rcnt};
			A_ASCLO: rd = {sarc_asc(s_r.rcnt[11:8]), sarc_asc(s_r.rcnt[15:12]),
				sarc_asc(s_r.rcnt[19:16]), sarc_asc(s_r.rcnt[23:20])};
			A_ASCHI: rd = {16'h0, sarc_asc(s_r.rcnt[3:0]), sarc_asc(s_r.rcnt[7:4])};
			A_LIMIT: rd = {7'h0, s_r.limEn, s_r.limit};
			A_KCFG:  rd = KCFG_VAL;
			default: begin
				if (s_r.dpAddr[7:4] == A_RCHAL)
					rd = s_r.chalA[{s_r.dpAddr[3:2], 5'h00} +: 32];
				else if (s_r.dpAddr[7:4] == A_TCHAL)
					rd = s_r.chalB[{s_r.dpAddr[3:2], 5'h00} +: 32];
				else if (s_r.dpAddr[7:5] == A_SVEC)
					rd = svVec[{~s_r.dpAddr[4:2], 5'h00} +: 32];
			end
		endcase

		// bus phases; reads take one wait state so they see prior writes
		if (s_r.rdPend) begin
			s_nxt.rdPend = 1'b0;
			s_nxt.ready = 1'b1;
			s_nxt.rdata = rd;
		end else if (hsel && hready && htrans[1]) begin
			s_nxt.dpAddr = (haddr[31:8] == 24'h0) ? {haddr[7:2], 2'b00} : 8'hfc;
			s_nxt.wrPend = hwrite;
			s_nxt.rdPend = !hwrite;
			s_nxt.ready = hwrite;
		end

		// plain register writes
		if (s_r.wrPend) begin
			if (s_r.dpAddr == A_TID)
				s_nxt.tidSeed = hwdata;
			if (s_r.dpAddr == A_LIMIT) begin
				s_nxt.limStage = hwdata[23:0];
				s_nxt.limStageEn = hwdata[F_LIMEN];
			end
			if (s_r.dpAddr[7:4] == A_RCHAL)
				s_nxt.chalA[{s_r.dpAddr[3:2], 5'h00} +: 32] = hwdata;
			if (s_r.dpAddr[7:4] == A_TCHAL)
				s_nxt.chalB[{s_r.dpAddr[3:2], 5'h00} +: 32] = hwdata;
		end

		// command execution
		if (cmdFire) begin
			s_nxt.err = 1'b0;
			// a foreign command aborts a pending second part
			if (waitAuth && (cOp != OP_P2OK) && (cOp != OP_P2FAIL) && (cOp != OP_CRYPT))
				authNow = AU_NONE;
			s_nxt.auth = authNow;
			case (cOp)
				OP_FIRST: begin
					s_nxt.cipher_block_counter = 32'h0;
					s_nxt.command_counter = 16'h0;
					s_nxt.tid = s_r.tidSeed;
					s_nxt.origin = hwdata[F_ORIG];
					s_nxt.auth = AU_WFIRST;
				end
				OP_RESUME: begin
					if ((authNow != AU_LRP) && !hwdata[F_ORIG]) begin
						s_nxt.auth = AU_NONE;
						s_nxt.err = 1'b1;
					end else begin
						// transaction id and command counter left alone
						s_nxt.cipher_block_counter = 32'h0;
						s_nxt.origin = hwdata[F_ORIG];
						s_nxt.auth = AU_WRES;
					end
				end
				OP_P2OK: begin
					if (waitAuth) begin
						s_nxt.auth = s_r.origin ? AU_NONE : AU_LRP;
					end else begin
						s_nxt.auth = AU_NONE;
						s_nxt.err = 1'b1;
					end
				end
				OP_P2FAIL: begin
					s_nxt.auth = AU_NONE;
					s_nxt.err = 1'b1;
				end
				OP_CRYPT: begin
					s_nxt.cipher_block_counter = s_r.cipher_block_counter + {27'h0, sarc_blocks(hwdata[F_LEN +: 8], hwdata[F_PAD])};
				end
				default: begin
				end
			endcase

			// a continuation of a chain is the same command
			if (!cChain && (cOp != OP_CRYPT)) begin
				if (cRead) begin
					s_nxt.lastType = cType;
					s_nxt.lastFile = cFile;
					if ((authNow == AU_NONE) && s_r.sdmOn && (cFile == s_r.sdmFile) && cFirst) begin
						if (s_r.rcnt == effLim) begin
							s_nxt.err = 1'b1;
							s_nxt.lastType = RT_NONE;
						end else begin
							s_nxt.rcnt = s_r.rcnt + 24'h000001;
						end
					end
				end else begin
					s_nxt.lastType = RT_NONE;
					s_nxt.lastFile = 5'h00;
				end
				if (cOp == OP_FSET) begin
					s_nxt.sdmOn = hwdata[F_SDMEN];
					if (hwdata[F_SDMEN]) begin
						s_nxt.rcnt = RCTR_RST;
						s_nxt.sdmFile = cFile;
						s_nxt.limit = s_r.limStage;
						s_nxt.limEn = s_r.limStageEn;
					end
				end
				if ((authNow == AU_LRP) && (cRead || (cOp == OP_OTHER) || (cOp == OP_FSET) || (cOp == OP_FQRY)))
					s_nxt.command_counter = s_r.command_counter + 16'h0001;
			end
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
			s_r.ready <= 1'b1;
			s_r.auth <= AU_NONE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hreadyout = s_r.ready;
	assign hresp     = s_r.resp;
	assign hrdata    = s_r.rdata;

	// ==========================================
	// checks
	property p_resume_refuse;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && (cOp == OP_RESUME) && (s_r.auth == AU_NONE) && !hwdata[F_ORIG]
		|=> s_r.err && (s_r.auth == AU_NONE);
	endproperty
	a_resume_refuse: assert property (p_resume_refuse) else $error("resume accepted without session");

	property p_resume_keep;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && (cOp == OP_RESUME) && (s_r.auth == AU_LRP)
		|=> $stable(s_r.tid) && $stable(s_r.command_counter) && (s_r.cipher_block_counter == 32'h0);
	endproperty
	a_resume_keep: assert property (p_resume_keep) else $error("resume changed id or counters");

	property p_first_clear;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && (cOp == OP_FIRST) |=> (s_r.cipher_block_counter == 32'h0) && (s_r.auth == AU_WFIRST);
	endproperty
	a_first_clear: assert property (p_first_clear) else $error("cipher counter not cleared");

	// second part of a resume on an ordinary key; a read between the parts aborts the resume
	sequence s_resume_part2;
		cmdFire && (cOp == OP_P2OK) && (s_r.auth == AU_WRES) && !s_r.origin;
	endsequence
	sequence s_lrp_held;
		(s_r.auth == AU_LRP) && !s_r.err;
	endsequence
	property p_resume_stay;
		@(posedge clock) disable iff (!arst_n)
		s_resume_part2 |=> s_lrp_held;
	endproperty
	a_resume_stay: assert property (p_resume_stay) else $error("resume did not stay authenticated");

	property p_fail_none;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && (cOp == OP_P2FAIL) |=> (s_r.auth == AU_NONE) && s_r.err;
	endproperty
	a_fail_none: assert property (p_fail_none) else $error("failure left authenticated");

	property p_sdm_clear;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && !cChain && (cOp == OP_FSET) && hwdata[F_SDMEN] |=> (s_r.rcnt == 24'h0) && s_r.sdmOn;
	endproperty
	a_sdm_clear: assert property (p_sdm_clear) else $error("read counter not cleared");

	property p_first_inc;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && cRead && !cChain && cFirst && (s_r.auth == AU_NONE) && s_r.sdmOn
		&& (cFile == s_r.sdmFile) && (s_r.rcnt != effLim)
		|=> (s_r.rcnt == $past(s_r.rcnt) + 24'h1) && !s_r.err;
	endproperty
	a_first_inc: assert property (p_first_inc) else $error("first read did not count");

	property p_reuse;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && cRead && (!cFirst || cChain || (s_r.auth == AU_LRP)) |=> $stable(s_r.rcnt);
	endproperty
	a_reuse: assert property (p_reuse) else $error("counter moved on repeat read");

	property p_limit;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && cRead && !cChain && cFirst && (s_r.auth == AU_NONE) && s_r.sdmOn
		&& (cFile == s_r.sdmFile) && (s_r.rcnt == effLim)
		|=> s_r.err && $stable(s_r.rcnt);
	endproperty
	a_limit: assert property (p_limit) else $error("read at limit not refused");

	property p_blocks;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && (cOp == OP_CRYPT) && hwdata[F_PAD] && (hwdata[F_LEN +: 8] == 8'h40)
		|=> (s_r.cipher_block_counter == $past(s_r.cipher_block_counter) + 32'd5);
	endproperty
	a_blocks: assert property (p_blocks) else $error("padded block count wrong");

	property p_read_wait;
		@(posedge clock) disable iff (!arst_n)
		s_r.rdPend |-> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

	// origin key session closes unauthenticated even on success
	property p_origin_end;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && (cOp == OP_P2OK) && waitAuth && s_r.origin |=> (s_r.auth == AU_NONE) && !s_r.err;
	endproperty
	a_origin_end: assert property (p_origin_end) else $error("origin key session left authenticated");

	// a second part with nothing pending is a protocol failure
	property p_p2_stray;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && (cOp == OP_P2OK) && !waitAuth |=> (s_r.auth == AU_NONE) && s_r.err;
	endproperty
	a_p2_stray: assert property (p_p2_stray) else $error("stray second part accepted");

	// foreign command while a second part is awaited drops the session
	property p_abort;
		@(posedge clock) disable iff (!arst_n)
		cmdFire && waitAuth && ((cOp == OP_OTHER) || cRead || (cOp == OP_FSET) || (cOp == OP_FQRY))
		|=> (s_r.auth == AU_NONE);
	endproperty
	a_abort: assert property (p_abort) else $error("pending authentication not aborted");

	// the read counter only moves on a command
	property p_rcnt_hold;
		@(posedge clock) disable iff (!arst_n)
		!cmdFire |=> $stable(s_r.rcnt);
	endproperty
	a_rcnt_hold: assert property (p_rcnt_hold) else $error("read counter moved without command");

	// elaboration guard: the config word must fill one bus word
	if ($bits(KCFG_VAL) != 32) begin
		$error("config word width");
	end
endmodule

// file: verif/sarc_reader_model.sv
// reader side stand-in: AHB-Lite master issuing single word transfers
// assumes one slave whose hreadyout is looped back as hready
`timescale 1ns/100ps
module sarc_reader_model (
	input  wire logic        clock,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	// ==========================================
	// bus idle at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// ==========================================
	// one transfer; waits as long as the slave stalls, only the watchdog ends a hang
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wr ? wd : ~hwdata;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
		// released lines flip so a stale value never reads as valid
		haddr <= ~haddr;
		hwdata <= ~hwdata;
	endtask
endmodule

// file: verif/tb.sv
// self-checking bench of the session auth / read counter block
// assumes the reader model as the only bus master
`timescale 1ns/100ps
module tb
	import sarc_pkg::*;
;
	logic         clock;
	logic         arst_n;
	logic         hsel;
	logic [31:0]  haddr;
	logic [1:0]   htrans;
	logic         hwrite;
	logic [2:0]   hsize;
	logic [31:0]  hwdata;
	logic         hreadyout;
	logic         hresp;
	logic [31:0]  hrdata;
	int           mismatches;
	int           samples_checked;
	logic [4:0]   f;
	logic [127:0] rc;
	logic [127:0] tc;
	logic [255:0] sv;
	logic [31:0]  seed;
	logic [31:0]  e0;
	logic [31:0]  c0;

	sarc_top dut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	sarc_reader_model rdr (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// ==========================================
	// clock and helpers
	always #2.5 clock = ~clock;

	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		rdr.xfer(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		rdr.xfer(1'b0, a, 32'h0, d);
	endtask
	// masked read compare, mask hides fields a scenario does not pin down
	task automatic chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] d;
		rd(a, d);
		compare(d & m, exp);
	endtask
	function automatic logic [31:0] cw(sarc_op_t op, logic [4:0] fl);
		return {23'h0, fl, op};
	endfunction
	// session vector, byte 0 in the top byte
	function automatic logic [255:0] sv_fn(logic [127:0] a, logic [127:0] b);
		return {32'h0001_0080, a[127:112], a[111:64] ^ b[127:80], b[79:0], a[63:0], 16'h9669};
	endfunction
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ==========================================
	// watchdog, far above the few hundred cycles the tests need
	initial begin
		repeat (40000) @(posedge clock);
		mismatches++;
		print_verdict();
	end

	// ==========================================
	// main sequence
	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		void'($urandom(32'h37916f4f));
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		// reset state, constant config, unmapped and read-only places
		chk(A_STAT, 32'h0, 32'h1f);
		chk(A_RCTR, 32'h0, '1);
		wr(A_KCFG, $urandom);
		chk(A_KCFG, 32'h0000_1010, '1);
		chk(8'hf0, 32'h0, '1);
		// session vector from random challenges
		rc = {$urandom, $urandom, $urandom, $urandom};
		tc = {$urandom, $urandom, $urandom, $urandom};
		for (int k = 0; k < 4; k++) begin
			wr({A_RCHAL, 2'(k), 2'b00}, rc[32*k +: 32]);
			wr({A_TCHAL, 2'(k), 2'b00}, tc[32*k +: 32]);
		end
		sv = sv_fn(rc, tc);
		for (int k = 0; k < 8; k++)
			chk({A_SVEC, 3'(k), 2'b00}, sv[255-32*k -: 32], '1);
		// read counter with limit 3 on a random file
		f = 5'($urandom);
		wr(A_LIMIT, 32'h0100_0003);
		wr(A_CMD, cw(OP_FSET, f) | (32'h1 << F_SDMEN));
		chk(A_RCTR, 32'h0, '1);
		chk(A_LIMIT, 32'h0100_0003, '1);
		wr(A_CMD, cw(OP_NRD, f));
		chk(A_RCTR, 32'h1, '1);
		wr(A_CMD, cw(OP_NRD, f));
		chk(A_RCTR, 32'h1, '1);
		wr(A_CMD, cw(OP_NRD, f) | (32'h1 << F_CHAIN));
		chk(A_RCTR, 32'h1, '1);
		wr(A_CMD, cw(OP_BRD, f));
		chk(A_RCTR, 32'h2, '1);
		wr(A_CMD, cw(OP_OTHER, f));
		wr(A_CMD, cw(OP_BRD, f));
		chk(A_RCTR, 32'h3, '1);
		wr(A_CMD, cw(OP_OTHER, f));
		wr(A_CMD, cw(OP_NRD, f));
		chk(A_STAT, 32'h4, 32'h7);
		chk(A_RCTR, 32'h3, '1);
		chk(A_ASCLO, 32'h3030_3030, '1);
		chk(A_ASCHI, 32'h0000_3330, '1);
		// resume without a session is refused
		wr(A_CMD, cw(OP_RESUME, 5'h0));
		chk(A_STAT, 32'h4, 32'h1f);
		// first authentication
		seed = $urandom;
		wr(A_TID, seed);
		wr(A_CMD, cw(OP_FIRST, 5'h0));
		chk(A_STAT, 32'h19, 32'h1f);
		chk(A_TID, seed, '1);
		wr(A_CMD, cw(OP_P2OK, 5'h0));
		chk(A_STAT, 32'h3, 32'h1f);
		// block counting, padded whole blocks and a partial block
		rd(A_ECTR, e0);
		wr(A_CMD, cw(OP_CRYPT, 5'h0) | (32'h1 << F_PAD) | (32'd64 << F_LEN));
		chk(A_ECTR, e0 + 32'd5, '1);
		wr(A_CMD, cw(OP_CRYPT, 5'h0) | (32'h1 << F_PAD) | (32'd20 << F_LEN));
		chk(A_ECTR, e0 + 32'd7, '1);
		// authenticated read at the limit is served and leaves the counter
		wr(A_CMD, cw(OP_NRD, f));
		chk(A_STAT, 32'h3, 32'h7);
		chk(A_RCTR, 32'h3, '1);
		rd(A_CCTR, c0);
		wr(A_CMD, cw(OP_OTHER, 5'h0));
		chk(A_CCTR, c0 + 32'd1, '1);
		// resume keeps id and command counter, clears block counter
		wr(A_TID, ~seed);
		wr(A_CMD, cw(OP_RESUME, 5'h0));
		chk(A_STAT, 32'ha, 32'h1f);
		chk(A_ECTR, 32'h0, '1);
		chk(A_TID, seed, '1);
		wr(A_CMD, cw(OP_P2OK, 5'h0));
		chk(A_STAT, 32'h3, 32'h1f);
		chk(A_CCTR, c0 + 32'd1, '1);
		// origin key resume ends unauthenticated
		wr(A_CMD, cw(OP_RESUME, 5'h0) | (32'h1 << F_ORIG));
		wr(A_CMD, cw(OP_P2OK, 5'h0));
		chk(A_STAT, 32'h0, 32'h3);
		// a second part with nothing pending fails
		wr(A_CMD, cw(OP_P2OK, 5'h0));
		chk(A_STAT, 32'h4, 32'h1f);
		// failed second part drops to none
		wr(A_CMD, cw(OP_FIRST, 5'h0));
		wr(A_CMD, cw(OP_P2FAIL, 5'h0));
		chk(A_STAT, 32'h4, 32'h1f);
		// a foreign command aborts a pending authentication
		wr(A_CMD, cw(OP_FIRST, 5'h0));
		wr(A_CMD, cw(OP_OTHER, 5'h0));
		chk(A_STAT, 32'h0, 32'h1f);
		// enabling dynamic messaging again restarts the counter, this time with the limit off
		wr(A_LIMIT, 32'h0000_0001);
		wr(A_CMD, cw(OP_FSET, f) | (32'h1 << F_SDMEN));
		chk(A_RCTR, 32'h0, '1);
		chk(A_LIMIT, 32'h0000_0001, '1);
		// a read of another file ends the run of repeats; a disabled limit blocks nothing
		wr(A_CMD, cw(OP_NRD, f));
		wr(A_CMD, cw(OP_NRD, f ^ 5'h01));
		wr(A_CMD, cw(OP_NRD, f));
		chk(A_RCTR, 32'h2, '1);
		chk(A_STAT, 32'h0, 32'h7);
		compare({31'h0, hresp}, 32'h0);
		print_verdict();
	end
endmodule
